//--- hdl/stc_timer.sv
`timescale 1ns/1ps
// Functional notes
// RULE1 - counter runs only while run bit set
// RULE2 - update suppress blocks every update event
// RULE3 - update from overflow, software, slave controller
// RULE4 - request source bit limits update requests
// RULE5 - one shot clears run at update
// RULE6 - reload buffered waits for update event
// RULE7 - sampling clock divides by 1, 2, 4
// RULE8 - buffered channel control applies on COM
// RULE9 - COM from trigger bit or trigger edge
// RULE10 - channel DMA on compare or update
// RULE11 - idle levels locked at lock level 1+
// RULE12 - interrupt and DMA enable bit positions
// RULE13 - update flag set by hardware, write-0 clears
// RULE14 - channel flag on match/capture, clear by read
// RULE15 - COM flag set by event, software clears
// RULE16 - break flag clear only when break inactive
// RULE17 - overcapture when capture meets set flag
// RULE18 - update trigger reinitialises counter and prescaler
// RULE19 - channel trigger sets flag, may capture
// RULE20 - commutation trigger makes COM event
// RULE21 - registers at fixed offsets 0x00..0x4c
// RULE22 - break clears main output enable at once
// RULE23 - interrupt while any enabled flag set
module stc_timer (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timer events in
  input  wire logic        trigger_input,
  input  wire logic        slave_trigger_start,
  input  wire logic        slave_update,
  input  wire logic        capture_in,
  input  wire logic        break_in,
  // outputs
  output logic             main_out,
  output logic             comp_out,
  output logic             sampling_tick,
  output logic             irq,
  output logic             update_dma_req,
  output logic             channel_dma_req
);
  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  stc_pkg::stc_state_t s;
  stc_pkg::stc_state_t next_s;

  logic        wr, rd, hit, brk_act, moe_eff, input_mode;
  logic        tick, ovf, ovf_ev, upd_ev, upd_req, com_ev, match, capture, cc_ev;
  logic        utrg_w, ctrg_w, mtrg_w, cnt_w;
  logic [15:0] reload_use, compare_use, wd, rdata;
  logic [1:0]  lock_lvl, div_lim;

  assign wr         = psel && penable && pwrite;
  assign rd         = psel && penable && !pwrite;
  assign wd         = pwdata[15:0];
  assign lock_lvl   = s.break_deadtime[stc_pkg::B_LOCK +: 2];
  assign input_mode = s.channel_mode[stc_pkg::B_SEL +: 2] != stc_pkg::SEL_OUT;
  assign utrg_w     = wr && paddr == stc_pkg::OFS_EGEN && wd[stc_pkg::B_UTRG];
  assign ctrg_w     = wr && paddr == stc_pkg::OFS_EGEN && wd[stc_pkg::B_CTRG];
  assign mtrg_w     = wr && paddr == stc_pkg::OFS_EGEN && wd[stc_pkg::B_MTRG];
  assign cnt_w      = wr && paddr == stc_pkg::OFS_CNT;

  always_comb begin
    unique case (paddr)
      stc_pkg::OFS_CTRL1: rdata = s.control_one;
      stc_pkg::OFS_CTRL2: rdata = s.control_two;
      stc_pkg::OFS_DIEN:  rdata = s.irq_dma_enable;
      stc_pkg::OFS_FLAGS: rdata = s.event_flags;
      stc_pkg::OFS_EGEN:  rdata = stc_pkg::RST_ZERO;
      stc_pkg::OFS_CCM:   rdata = s.channel_mode;
      stc_pkg::OFS_CCEN:  rdata = s.channel_enable_polarity;
      stc_pkg::OFS_CNT:   rdata = s.count_value;
      stc_pkg::OFS_PSC:   rdata = s.clock_prescale;
      stc_pkg::OFS_ARR:   rdata = s.reload_value;
      stc_pkg::OFS_REP:   rdata = s.repetition_count;
      stc_pkg::OFS_CCR:   rdata = s.channel_value;
      stc_pkg::OFS_BDT:   rdata = s.break_deadtime;
      stc_pkg::OFS_DCTRL: rdata = s.burst_dma_setup;
      stc_pkg::OFS_DADDR: rdata = s.burst_dma_window;
      default:            rdata = stc_pkg::RST_ZERO;
    endcase
  end
  assign hit = paddr inside {stc_pkg::OFS_CTRL1, stc_pkg::OFS_CTRL2, stc_pkg::OFS_DIEN,
                             stc_pkg::OFS_FLAGS, stc_pkg::OFS_EGEN, stc_pkg::OFS_CCM,
                             stc_pkg::OFS_CCEN, stc_pkg::OFS_CNT, stc_pkg::OFS_PSC,
                             stc_pkg::OFS_ARR, stc_pkg::OFS_REP, stc_pkg::OFS_CCR,
                             stc_pkg::OFS_BDT, stc_pkg::OFS_DCTRL, stc_pkg::OFS_DADDR}; // RULE21

  // ---------------------------------------------------------------
  // counting and events
  // ---------------------------------------------------------------
  // break acts on the outputs combinationally; the stored enable follows next edge
  assign brk_act = s.break_deadtime[stc_pkg::B_BRKEN] &&
                   (break_in == s.break_deadtime[stc_pkg::B_BRKPOL]);
  assign moe_eff = s.break_deadtime[stc_pkg::B_MOE] && !brk_act; // RULE22
  assign reload_use  = s.control_one[stc_pkg::B_ARP] ? s.reload_act : s.reload_value; // RULE6
  assign compare_use = s.channel_mode[stc_pkg::B_OCPRE] ? s.compare_act : s.channel_value;
  assign tick    = s.control_one[stc_pkg::B_RUN] && s.prescale_cnt == s.prescale_act; // RULE1
  assign ovf     = tick && s.count_value >= reload_use;
  assign ovf_ev  = ovf && s.repeat_cnt == 8'h00;
  assign upd_ev  = !s.control_one[stc_pkg::B_USUP] && (ovf_ev || utrg_w || slave_update); // RULE2 RULE3
  assign upd_req = upd_ev && (!s.control_one[stc_pkg::B_URS] || ovf_ev); // RULE4
  assign com_ev  = mtrg_w || (s.control_two[stc_pkg::B_CCP] && s.control_two[stc_pkg::B_CCU] &&
                   trigger_input && !s.trig_q); // RULE9 RULE20
  assign match   = !input_mode && s.control_one[stc_pkg::B_RUN] &&
                   s.prescale_cnt == stc_pkg::RST_ZERO && s.count_value == compare_use;
  assign capture = input_mode && ((capture_in && s.act_en) || ctrg_w); // RULE19
  assign cc_ev   = match || capture || ctrg_w; // RULE14 RULE19

  always_comb begin
    unique case (s.control_one[stc_pkg::B_DIV +: 2])
      stc_pkg::DIV2: div_lim = stc_pkg::LIM2;
      stc_pkg::DIV4: div_lim = stc_pkg::LIM4;
      default:       div_lim = stc_pkg::LIM1; // reserved code runs undivided
    endcase
  end

  // output compare mode codes, named here so the case below reads plainly
  localparam logic [2:0] OM_SEL_HI = stc_pkg::OM_HI, OM_SEL_LO = stc_pkg::OM_LO;
  localparam logic [2:0] OM_SEL_TG = stc_pkg::OM_TGL, OM_SEL_FL = stc_pkg::OM_FLO;
  localparam logic [2:0] OM_SEL_FH = stc_pkg::OM_FHI, OM_SEL_P1 = stc_pkg::OM_PWM1;
  localparam logic [2:0] OM_SEL_P2 = stc_pkg::OM_PWM2;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.upd_dma = 1'b0;
    next_s.ch_dma  = 1'b0;
    next_s.trig_q  = trigger_input;
    // apb setup phase captures read data so the access phase sees a flop
    if (psel && !penable) begin
      next_s.prdata = {16'h0000, rdata};
    end
    // software writes
    if (wr) begin
      unique case (paddr)
        stc_pkg::OFS_CTRL1: next_s.control_one = wd & stc_pkg::M_CTRL1;
        stc_pkg::OFS_CTRL2: begin
          next_s.control_two = wd & stc_pkg::M_CTRL2;
          if (lock_lvl != stc_pkg::LVL0) begin
            next_s.control_two = (wd & stc_pkg::M_CTRL2 & ~stc_pkg::M_IDLE) |
                                 (s.control_two & stc_pkg::M_IDLE); // RULE11
          end
        end
        stc_pkg::OFS_DIEN:  next_s.irq_dma_enable = wd & stc_pkg::M_DIEN; // RULE12
        stc_pkg::OFS_FLAGS: next_s.event_flags = s.event_flags & wd; // RULE13
        stc_pkg::OFS_CCM: begin
          next_s.channel_mode = wd & stc_pkg::M_CCM;
          if (lock_lvl == 2'h3 && !input_mode) begin
            next_s.channel_mode = (wd & stc_pkg::M_CCM & ~stc_pkg::M_CCM3) |
                                  (s.channel_mode & stc_pkg::M_CCM3);
          end
        end
        stc_pkg::OFS_CCEN: begin
          next_s.channel_enable_polarity = wd & stc_pkg::M_CCEN;
          if (lock_lvl >= stc_pkg::LVL2) begin
            next_s.channel_enable_polarity = (wd & stc_pkg::M_CCEN & ~stc_pkg::M_POL) |
                                             (s.channel_enable_polarity & stc_pkg::M_POL);
          end
        end
        stc_pkg::OFS_CNT:   next_s.count_value = wd;
        stc_pkg::OFS_PSC:   next_s.clock_prescale = wd;
        stc_pkg::OFS_ARR:   next_s.reload_value = wd;
        stc_pkg::OFS_REP:   next_s.repetition_count = wd & stc_pkg::M_REP;
        stc_pkg::OFS_CCR:   next_s.channel_value = wd;
        stc_pkg::OFS_BDT: begin
          next_s.break_deadtime = wd;
          // lock field is write-once after reset
          if (s.lock_done) begin
            next_s.break_deadtime = (wd & ~stc_pkg::M_LOCKF) | (s.break_deadtime & stc_pkg::M_LOCKF);
          end
          if (lock_lvl != stc_pkg::LVL0) begin
            next_s.break_deadtime = (next_s.break_deadtime & ~stc_pkg::M_LOCK1) |
                                    (s.break_deadtime & stc_pkg::M_LOCK1);
          end
          if (lock_lvl >= stc_pkg::LVL2) begin
            next_s.break_deadtime = (next_s.break_deadtime & ~stc_pkg::M_LOCK2) |
                                    (s.break_deadtime & stc_pkg::M_LOCK2);
          end
          next_s.lock_done = 1'b1;
        end
        stc_pkg::OFS_DCTRL: next_s.burst_dma_setup = wd & stc_pkg::M_DCTRL;
        stc_pkg::OFS_DADDR: next_s.burst_dma_window = wd;
        default: ;
      endcase
    end
    // reading the capture register acknowledges the channel flag
    if (rd && paddr == stc_pkg::OFS_CCR) begin
      next_s.event_flags[stc_pkg::B_CH] = 1'b0; // RULE14
    end
    // counter and prescaler
    if (s.control_one[stc_pkg::B_RUN]) begin
      next_s.prescale_cnt = tick ? stc_pkg::RST_ZERO : 16'(s.prescale_cnt + 16'h0001);
    end
    if (tick && !cnt_w) begin
      next_s.count_value = ovf ? stc_pkg::RST_ZERO : 16'(s.count_value + 16'h0001);
    end
    if (ovf) begin
      next_s.repeat_cnt = (s.repeat_cnt == 8'h00) ? s.repetition_count[7:0] :
                          8'(s.repeat_cnt - 8'h01);
    end
    if (utrg_w) begin
      next_s.prescale_cnt = stc_pkg::RST_ZERO; // RULE18
      if (!cnt_w) begin
        next_s.count_value = stc_pkg::RST_ZERO; // RULE18
      end
    end
    // shadow transfer only on an allowed update
    if (upd_ev) begin
      next_s.reload_act   = s.reload_value; // RULE6
      next_s.prescale_act = s.clock_prescale;
      next_s.compare_act  = s.channel_value;
      next_s.repeat_cnt   = s.repetition_count[7:0];
      if (s.break_deadtime[stc_pkg::B_AOE] && !brk_act) begin
        next_s.break_deadtime[stc_pkg::B_MOE] = 1'b1;
      end
    end
    if (slave_trigger_start) begin
      next_s.control_one[stc_pkg::B_RUN] = 1'b1; // RULE1
    end
    if (upd_ev && s.control_one[stc_pkg::B_OSM]) begin
      next_s.control_one[stc_pkg::B_RUN] = 1'b0; // RULE5
    end
    // channel control: immediate, or held until a COM event
    if (!s.control_two[stc_pkg::B_CCP] || com_ev) begin
      next_s.act_en   = s.channel_enable_polarity[stc_pkg::B_EN]; // RULE8
      next_s.act_nen  = s.channel_enable_polarity[stc_pkg::B_NEN];
      next_s.act_mode = s.channel_mode[stc_pkg::B_MODE +: 3];
    end
    // reference waveform; one shot leaves it where it stopped
    unique case (s.act_mode)
      OM_SEL_HI: if (match) next_s.oc_ref = 1'b1;
      OM_SEL_LO: if (match) next_s.oc_ref = 1'b0;
      OM_SEL_TG: if (match) next_s.oc_ref = !s.oc_ref;
      OM_SEL_FL: next_s.oc_ref = 1'b0;
      OM_SEL_FH: next_s.oc_ref = 1'b1;
      OM_SEL_P1: next_s.oc_ref = s.count_value < compare_use;
      OM_SEL_P2: next_s.oc_ref = !(s.count_value < compare_use);
      default:   ;
    endcase
    if (capture) begin
      next_s.channel_value = s.count_value;
    end
    // flag sets come last so an event beats a clear in the same cycle
    if (upd_req) next_s.event_flags[stc_pkg::B_UPD] = 1'b1; // RULE13
    if (cc_ev) next_s.event_flags[stc_pkg::B_CH] = 1'b1; // RULE14
    if (com_ev) next_s.event_flags[stc_pkg::B_COM] = 1'b1; // RULE15
    if (brk_act) next_s.event_flags[stc_pkg::B_BRK] = 1'b1; // RULE16
    if (capture && s.event_flags[stc_pkg::B_CH]) begin
      next_s.event_flags[stc_pkg::B_OVC] = 1'b1; // RULE17
    end
    if (brk_act) begin
      next_s.break_deadtime[stc_pkg::B_MOE] = 1'b0; // RULE22
    end
    // dma pulses
    next_s.upd_dma = upd_req && s.irq_dma_enable[stc_pkg::B_UDMA]; // RULE12
    next_s.ch_dma  = s.irq_dma_enable[stc_pkg::B_CDMA] &&
                     (s.control_two[stc_pkg::B_CDS] ? upd_req : cc_ev); // RULE10
    // sampling clock divider
    next_s.samp    = s.div_cnt >= div_lim; // RULE7
    next_s.div_cnt = (s.div_cnt >= div_lim) ? 2'h0 : 2'(s.div_cnt + 2'h1);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s            <= '0;
      s.reload_value <= stc_pkg::RST_ARR;
      s.reload_act <= stc_pkg::RST_ARR;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata  = s.prdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign irq     = |(s.event_flags & s.irq_dma_enable &
                     (stc_pkg::M_FLAGS & ~(16'h0001 << stc_pkg::B_OVC))); // RULE23
  assign update_dma_req  = s.upd_dma;
  assign channel_dma_req = s.ch_dma;
  assign sampling_tick   = s.samp;
  // while the main output enable is clear or a break is active the outputs fall to the programmed idle levels
  assign main_out = moe_eff ? (s.act_en && s.oc_ref) ^ s.channel_enable_polarity[stc_pkg::B_POL]
                            : s.control_two[stc_pkg::B_IDLE]; // RULE11
  assign comp_out = moe_eff ? (s.act_nen && !s.oc_ref) ^ s.channel_enable_polarity[stc_pkg::B_NPOL]
                            : s.control_two[stc_pkg::B_IDLEN];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_SUPPRESS: assert property (s.control_one[stc_pkg::B_USUP] |=> $stable(s.reload_act)) // RULE2
    else $error("shadow reload changed while updates suppressed");
  AST_UPD_FLAG: assert property (upd_req |=> s.event_flags[stc_pkg::B_UPD]) // RULE13
    else $error("update flag not set by update request");
  AST_URS: assert property (upd_ev && !upd_req && !s.event_flags[stc_pkg::B_UPD]
                            |=> !s.event_flags[stc_pkg::B_UPD]) // RULE4
    else $error("update flag set by filtered source");
  AST_ONESHOT: assert property (upd_ev && s.control_one[stc_pkg::B_OSM]
                                |=> !s.control_one[stc_pkg::B_RUN]) // RULE5
    else $error("one shot did not stop counter");
  AST_UTRIG: assert property (utrg_w && !cnt_w
                              |=> s.count_value == 16'h0000 && s.prescale_cnt == 16'h0000) // RULE18
    else $error("update trigger did not reinitialise counter");
  AST_CH_FLAG: assert property (cc_ev |=> s.event_flags[stc_pkg::B_CH]) // RULE14
    else $error("channel flag missed");
  AST_OVC: assert property (capture && s.event_flags[stc_pkg::B_CH]
                            |=> s.event_flags[stc_pkg::B_OVC]) // RULE17
    else $error("overcapture flag missed");
  AST_COM: assert property (mtrg_w |=> s.event_flags[stc_pkg::B_COM]) // RULE15
    else $error("commutation flag missed");
  AST_BRK: assert property (brk_act |=> s.event_flags[stc_pkg::B_BRK]
                            && !s.break_deadtime[stc_pkg::B_MOE]) // RULE16
    else $error("break flag or main enable wrong");
  AST_DMA: assert property (cc_ev && !s.control_two[stc_pkg::B_CDS] &&
                            s.irq_dma_enable[stc_pkg::B_CDMA] |=> channel_dma_req) // RULE10
    else $error("channel dma request missed");
  AST_DIV4: assert property (s.samp && s.control_one[stc_pkg::B_DIV +: 2] == stc_pkg::DIV4 && !wr
                             |=> !s.samp ##1 !s.samp) // RULE7
    else $error("sampling tick too early");

  COV_OVF: cover property (ovf_ev && upd_req);
  COV_OVC: cover property (capture && s.event_flags[stc_pkg::B_CH]);
  COV_COM_EDGE: cover property (com_ev && !mtrg_w);
  COV_BRK: cover property (brk_act && s.break_deadtime[stc_pkg::B_MOE]);
endmodule // stc_timer

//--- include/stc_pkg.sv
package stc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_DIEN  = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_EGEN  = 8'h14;
  localparam logic [7:0] OFS_CCM   = 8'h18;
  localparam logic [7:0] OFS_CCEN  = 8'h20;
  localparam logic [7:0] OFS_CNT   = 8'h24;
  localparam logic [7:0] OFS_PSC   = 8'h28;
  localparam logic [7:0] OFS_ARR   = 8'h2c;
  localparam logic [7:0] OFS_REP   = 8'h30;
  localparam logic [7:0] OFS_CCR   = 8'h34;
  localparam logic [7:0] OFS_BDT   = 8'h44;
  localparam logic [7:0] OFS_DCTRL = 8'h48;
  localparam logic [7:0] OFS_DADDR = 8'h4c;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int B_RUN = 0, B_USUP = 1, B_URS = 2, B_OSM = 3, B_ARP = 7, B_DIV = 8;
  localparam int B_CCP = 0, B_CCU = 2, B_CDS = 3, B_IDLE = 8, B_IDLEN = 9;
  localparam int B_UPD = 0, B_CH = 1, B_COM = 5, B_BRK = 7, B_UDMA = 8, B_CDMA = 9;
  localparam int B_OVC = 9, B_UTRG = 0, B_CTRG = 1, B_MTRG = 5;
  localparam int B_SEL = 0, B_OCPRE = 3, B_MODE = 4;
  localparam int B_EN = 0, B_POL = 1, B_NEN = 2, B_NPOL = 3;
  localparam int B_LOCK = 8, B_BRKEN = 12, B_BRKPOL = 13, B_AOE = 14, B_MOE = 15;
  // ---------------------------------------------------------------
  // writable masks, reset values, codes
  // ---------------------------------------------------------------
  localparam logic [15:0] M_CTRL1 = 16'h038f, M_CTRL2 = 16'h030d, M_DIEN = 16'h03a3;
  localparam logic [15:0] M_FLAGS = 16'h02a3, M_CCM = 16'h00ff, M_CCEN = 16'h000f;
  localparam logic [15:0] M_REP = 16'h00ff, M_DCTRL = 16'h1f1f;
  localparam logic [15:0] M_LOCK1 = 16'h70ff, M_LOCK2 = 16'h0c00, M_POL = 16'h000a;
  localparam logic [15:0] M_CCM3 = 16'h0078, M_IDLE = 16'h0300, M_LOCKF = 16'h0300;
  localparam logic [15:0] RST_ZERO = 16'h0000, RST_ARR = 16'hffff;
  localparam logic [1:0] DIV1 = 2'h0, DIV2 = 2'h1, DIV4 = 2'h2, LVL0 = 2'h0, LVL2 = 2'h2;
  localparam logic [1:0] LIM1 = 2'h0, LIM2 = 2'h1, LIM4 = 2'h3, SEL_OUT = 2'h0;
  localparam logic [2:0] OM_HI = 3'h1, OM_LO = 3'h2, OM_TGL = 3'h3, OM_FLO = 3'h4;
  localparam logic [2:0] OM_FHI = 3'h5, OM_PWM1 = 3'h6, OM_PWM2 = 3'h7;
  // ---------------------------------------------------------------
  // whole state of the timer
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] control_one, control_two, irq_dma_enable, event_flags;
    logic [15:0] channel_mode, channel_enable_polarity, count_value;
    logic [15:0] clock_prescale, reload_value, repetition_count, channel_value;
    logic [15:0] break_deadtime, burst_dma_setup, burst_dma_window;
    logic [15:0] reload_act, prescale_act, compare_act, prescale_cnt;
    logic [7:0]  repeat_cnt;
    logic        act_en, act_nen;
    logic [2:0]  act_mode;
    logic        oc_ref, lock_done, trig_q, samp, upd_dma, ch_dma;
    logic [1:0]  div_cnt;
    logic [31:0] prdata;
  } stc_state_t;
endpackage

//--- tb/stc_timer_tb.sv
`timescale 1ns/1ps
module single_channel_advanced_timer_control_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        core_clk = 1'b0, resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e;
  logic        trigger_input = 1'b0, slave_trigger_start = 1'b0, slave_update = 1'b0;
  logic        capture_in = 1'b0, break_in = 1'b0;
  logic        main_out, comp_out, sampling_tick, irq, update_dma_req, channel_dma_req;
  int          bad_count = 0, tests_run = 0, c, n;
  stc_timer dut_u (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_input(trigger_input), .slave_trigger_start(slave_trigger_start),
    .slave_update(slave_update), .capture_in(capture_in), .break_in(break_in),
    .main_out(main_out), .comp_out(comp_out), .sampling_tick(sampling_tick), .irq(irq),
    .update_dma_req(update_dma_req), .channel_dma_req(channel_dma_req));
  always #5 core_clk = ~core_clk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict;
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 20) begin
      bad_count++;
      give_verdict();
    end
    // values read here are those standing at the edge that completes the access
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r & m, exp);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset_map;
    rd_chk("ctrl1", stc_pkg::OFS_CTRL1, 32'hffffffff, 32'h0);
    rd_chk("reload", stc_pkg::OFS_ARR, 32'hffffffff, 32'hffff);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped_err", {31'h0, e}, 32'h1);
  endtask
  task automatic s_update;
    wr(stc_pkg::OFS_DIEN, 32'h0101);
    wr(stc_pkg::OFS_EGEN, 32'h0001);
    @(negedge core_clk);
    chk("upd_dma", {31'h0, update_dma_req}, 32'h1);
    rd_chk("flags_ueg", stc_pkg::OFS_FLAGS, 32'h02a3, 32'h0001);
    chk("irq_update", {31'h0, irq}, 32'h1);
    wr(stc_pkg::OFS_FLAGS, 32'hffff);
    rd_chk("flags_w1", stc_pkg::OFS_FLAGS, 32'h0001, 32'h0001);
    wr(stc_pkg::OFS_FLAGS, 32'h0000);
    rd_chk("flags_w0", stc_pkg::OFS_FLAGS, 32'h0001, 32'h0000);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    @(posedge core_clk) slave_update <= 1'b1;
    @(posedge core_clk) slave_update <= 1'b0;
    rd_chk("flags_slave", stc_pkg::OFS_FLAGS, 32'h0001, 32'h0001);
    wr(stc_pkg::OFS_FLAGS, 32'h0000);
  endtask
  task automatic s_suppress;
    for (int i = 0; i < 2; i++) begin
      wr(stc_pkg::OFS_CTRL1, i == 0 ? 32'h0002 : 32'h0004);
      wr(stc_pkg::OFS_EGEN, 32'h0001);
      @(posedge core_clk) slave_update <= 1'b1;
      @(posedge core_clk) slave_update <= 1'b0;
      rd_chk("flags_blocked", stc_pkg::OFS_FLAGS, 32'h0001, 32'h0000);
    end
  endtask
  task automatic s_chan_com;
    wr(stc_pkg::OFS_DIEN, 32'h0200);
    wr(stc_pkg::OFS_EGEN, 32'h0002);
    @(negedge core_clk);
    chk("ch_dma", {31'h0, channel_dma_req}, 32'h1);
    rd_chk("flags_cc", stc_pkg::OFS_FLAGS, 32'h02a3, 32'h0002);
    apb(1'b0, stc_pkg::OFS_CCR, 32'h0);
    rd_chk("flags_ccread", stc_pkg::OFS_FLAGS, 32'h0002, 32'h0000);
    wr(stc_pkg::OFS_EGEN, 32'h0020);
    rd_chk("flags_com", stc_pkg::OFS_FLAGS, 32'h02a3, 32'h0020);
    wr(stc_pkg::OFS_FLAGS, 32'h0000);
  endtask
  // one shot with overflow as the only request source
  task automatic s_one_shot;
    wr(stc_pkg::OFS_ARR, 32'h0003);
    wr(stc_pkg::OFS_CTRL1, 32'h000d);
    n = 0;
    r = 32'h0;
    while (r[0] !== 1'b1 && n < 30) begin
      apb(1'b0, stc_pkg::OFS_FLAGS, 32'h0);
      n++;
    end
    chk("ovf_flag", {31'h0, r[0]}, 32'h1);
    rd_chk("ctrl1_stop", stc_pkg::OFS_CTRL1, 32'hffff, 32'h000c);
    rd_chk("count_wrap", stc_pkg::OFS_CNT, 32'hffff, 32'h0);
    rd_chk("count_held", stc_pkg::OFS_CNT, 32'hffff, 32'h0);
    wr(stc_pkg::OFS_CTRL1, 32'h0000);
    wr(stc_pkg::OFS_FLAGS, 32'h0000);
  endtask
  task automatic s_divider;
    int exp_t [4] = '{8, 4, 2, 8};
    for (int i = 0; i < 4; i++) begin
      wr(stc_pkg::OFS_CTRL1, 32'(i) << 8);
      repeat (4) @(posedge core_clk);
      c = 0;
      repeat (8) begin
        @(negedge core_clk);
        if (sampling_tick === 1'b1) c++;
      end
      chk("tick_count", c, exp_t[i]);
    end
    wr(stc_pkg::OFS_CTRL1, 32'h0000);
  endtask
  // lock level 1 in the same first write that arms an active-high break
  task automatic s_lock_break;
    wr(stc_pkg::OFS_BDT, 32'h3100);
    wr(stc_pkg::OFS_CTRL2, 32'h0300);
    rd_chk("idle_locked", stc_pkg::OFS_CTRL2, 32'h0300, 32'h0000);
    wr(stc_pkg::OFS_BDT, 32'hb100);
    wr(stc_pkg::OFS_CCEN, 32'h000a);
    wr(stc_pkg::OFS_DIEN, 32'h0080);
    chk("main_run", {31'h0, main_out}, 32'h1);
    chk("comp_run", {31'h0, comp_out}, 32'h1);
    @(posedge core_clk) break_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd_chk("brk_flag", stc_pkg::OFS_FLAGS, 32'h0080, 32'h0080);
    chk("main_idle", {31'h0, main_out}, 32'h0);
    chk("comp_idle", {31'h0, comp_out}, 32'h0);
    chk("irq_brk", {31'h0, irq}, 32'h1);
    wr(stc_pkg::OFS_FLAGS, 32'h0000);
    rd_chk("brk_stuck", stc_pkg::OFS_FLAGS, 32'h0080, 32'h0080);
    rd_chk("moe_off", stc_pkg::OFS_BDT, 32'h8000, 32'h0000);
    @(posedge core_clk) break_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr(stc_pkg::OFS_FLAGS, 32'h0000);
    rd_chk("brk_clear", stc_pkg::OFS_FLAGS, 32'h0080, 32'h0000);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    s_reset_map();
    s_update();
    s_suppress();
    s_chan_com();
    s_one_shot();
    s_divider();
    s_lock_break();
    give_verdict();
  end
endmodule // single_channel_advanced_timer_control_tb
